//--- hdl/ogbr_pkg.sv
// Package: constants and types shared by both ends of the output gate and bus reset link
package ogbr_pkg;
  localparam int NUM_CH = 16;
  localparam int CLK_PERIOD_NS = 8;
  // Host divider: one quarter of the serial clock period
  localparam int SCL_QUARTER_NS = 250;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] QTR_LAST = 6'(SCL_QUARTER_CYC - 1);
  // Reset-call bytes and framing
  localparam logic [7:0] GEN_CALL_WRITE = 8'h00;
  localparam logic [7:0] RESET_CMD_BYTE = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Disabled-output level codes
  localparam logic [1:0] DIS_LOW = 2'h0;
  localparam logic [1:0] DIS_HIGH = 2'h1;
  // Output config word layout and power-up value
  localparam int CFG_DIS_LSB = 0;
  localparam int CFG_DRIVE_BIT = 2;
  localparam int CFG_INVERT_BIT = 3;
  localparam logic [3:0] CFG_RST = 4'h4;
  localparam logic LINE_IDLE = 1'b1;
  // Host register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_GO = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_SEND_BIT = 16;
  localparam int CMD_EXTRA_BIT = 17;
  localparam int GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ABORT_BIT = 2;
  localparam logic [31:0] CMD_RST = 32'h0001_0600;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_ACK_ADDR = 3'h2,
    D_BYTE1 = 3'h3,
    D_ACK_BYTE1 = 3'h4,
    D_ARMED = 3'h5,
    D_SKIP = 3'h6
  } ogbr_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BITS = 2'h2,
    H_STOP = 2'h3
  } ogbr_host_state_t;
endpackage

//--- hdl/ogbr_link_if.sv
// Interface: two-wire serial link between the host master and the device
`timescale 1ns/1ps
`default_nettype none
interface ogbr_link_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSclOut;
  logic devSclOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: low while any enabled driver pulls low
  assign scl = !((hostSclOe && !hostSclOut) || (devSclOe && !devSclOut));
  assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport dev (
    input scl,
    input sda,
    output devSclOut,
    output devSclOe,
    output devSdaOut,
    output devSdaOe
  );

  modport host (
    input scl,
    input sda,
    output hostSclOut,
    output hostSclOe,
    output hostSdaOut,
    output hostSdaOe
  );
endinterface
`default_nettype wire

//--- hdl/ogbr_device.sv
// Device end: channel output gating and serial-bus reset-call detector
`timescale 1ns/1ps
`default_nettype none
module ogbr_device
  import ogbr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic outEnableN,
  input wire logic [NUM_CH-1:0] pwmState,
  input wire logic cfgWrite,
  input wire logic [3:0] cfgData,
  output logic [3:0] cfgState,
  output logic [NUM_CH-1:0] chanOut,
  output logic [NUM_CH-1:0] chanOe,
  output logic softResetPulse,
  ogbr_link_if.dev link
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0] oenSync;
    logic oenF;
    logic [2:0] sclSync;
    logic sclF;
    logic [2:0] sdaSync;
    logic sdaF;
    ogbr_dev_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic sdaOe;
    logic [3:0] cfg;
    logic [NUM_CH-1:0] chanOut;
    logic [NUM_CH-1:0] chanOe;
    logic softRst;
  } ogbr_dev_s_t;

  // Power-up values: lines idle high, outputs disabled and driven low
  localparam ogbr_dev_s_t DEV_RST = '{
    oenSync: {3{LINE_IDLE}},
    oenF: LINE_IDLE,
    sclSync: {3{LINE_IDLE}},
    sclF: LINE_IDLE,
    sdaSync: {3{LINE_IDLE}},
    sdaF: LINE_IDLE,
    st: D_IDLE,
    bitCnt: 4'h0,
    shift: 8'h00,
    sdaOe: 1'b0,
    cfg: CFG_RST,
    chanOut: {NUM_CH{1'b0}},
    chanOe: {NUM_CH{1'b1}},
    softRst: 1'b0
  };

  ogbr_dev_s_t s_reg;
  ogbr_dev_s_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Pad driver: returns {out, oe}; open-drain only ever pulls low

  function automatic logic [1:0] padDrive(input logic level, input logic pushPull);
    if (pushPull) begin
      padDrive = {level, 1'b1};
    end else begin
      padDrive = {1'b0, !level};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic invert;
    logic pushPull;
    logic [1:0] disLevel;
    sclRise = 1'b0;
    sclFall = 1'b0;
    startSeen = 1'b0;
    stopSeen = 1'b0;
    invert = s_reg.cfg[CFG_INVERT_BIT];
    pushPull = s_reg.cfg[CFG_DRIVE_BIT];
    disLevel = s_reg.cfg[CFG_DIS_LSB +: 2];
    s_next = s_reg;
    s_next.softRst = 1'b0;

    // Three-stage synchronisers; a level counts once stages two and three agree
    s_next.oenSync = {s_reg.oenSync[1:0], outEnableN};
    s_next.sclSync = {s_reg.sclSync[1:0], link.scl};
    s_next.sdaSync = {s_reg.sdaSync[1:0], link.sda};
    if (s_reg.oenSync[1] == s_reg.oenSync[2]) begin
      s_next.oenF = s_reg.oenSync[2];
    end
    if (s_reg.sclSync[1] == s_reg.sclSync[2]) begin
      s_next.sclF = s_reg.sclSync[2];
    end
    if (s_reg.sdaSync[1] == s_reg.sdaSync[2]) begin
      s_next.sdaF = s_reg.sdaSync[2];
    end

    // Bus conditions; data moving under a high clock is control, not data
    sclRise = !s_reg.sclF && s_next.sclF;
    sclFall = s_reg.sclF && !s_next.sclF;
    startSeen = s_reg.sclF && s_next.sclF && s_reg.sdaF && !s_next.sdaF;
    stopSeen = s_reg.sclF && s_next.sclF && !s_reg.sdaF && s_next.sdaF;

    // Local config port
    if (cfgWrite) begin
      s_next.cfg = cfgData;
    end

    // Reset-call detector
    if (stopSeen) begin
      if (s_reg.st == D_ARMED) begin
        s_next.cfg = CFG_RST;
        s_next.softRst = 1'b1;
      end
      s_next.st = D_IDLE;
      s_next.sdaOe = 1'b0;
      s_next.bitCnt = 4'h0;
    end else if (startSeen) begin
      s_next.st = D_ADDR;
      s_next.sdaOe = 1'b0;
      s_next.bitCnt = 4'h0;
    end else begin
      // Shift data in on the rising clock, MSB first
      if (sclRise && (s_reg.st == D_ADDR || s_reg.st == D_BYTE1)
          && s_reg.bitCnt != BITS_PER_BYTE) begin
        s_next.shift = {s_reg.shift[6:0], s_reg.sdaF};
        s_next.bitCnt = s_reg.bitCnt + 4'h1;
      end
      // Acknowledge is set up and released on falling clocks only
      if (sclFall) begin
        unique case (s_reg.st)
          D_ADDR: begin
            if (s_reg.bitCnt == BITS_PER_BYTE) begin
              if (s_reg.shift == GEN_CALL_WRITE) begin
                s_next.st = D_ACK_ADDR;
                s_next.sdaOe = 1'b1;
              end else begin
                // Read direction or other address: stay silent
                s_next.st = D_SKIP;
              end
            end
          end
          D_ACK_ADDR: begin
            s_next.st = D_BYTE1;
            s_next.sdaOe = 1'b0;
            s_next.bitCnt = 4'h0;
          end
          D_BYTE1: begin
            if (s_reg.bitCnt == BITS_PER_BYTE) begin
              if (s_reg.shift == RESET_CMD_BYTE) begin
                s_next.st = D_ACK_BYTE1;
                s_next.sdaOe = 1'b1;
              end else begin
                s_next.st = D_SKIP;
              end
            end
          end
          D_ACK_BYTE1: begin
            s_next.st = D_ARMED;
            s_next.sdaOe = 1'b0;
            s_next.bitCnt = 4'h0;
          end
          D_ARMED: begin
            // A further clock means an extra byte: no ack, call dropped
            s_next.st = D_SKIP;
          end
          D_IDLE, D_SKIP: begin
            s_next.st = s_reg.st;
          end
          default: begin
            s_next.st = D_IDLE;
            s_next.sdaOe = 1'b0;
          end
        endcase
      end
    end

    // Channel outputs; one enable level for every channel
    for (int i = 0; i < NUM_CH; i++) begin
      if (!s_reg.oenF) begin
        {s_next.chanOut[i], s_next.chanOe[i]} =
          padDrive(pwmState[i] ^ invert, pushPull);
      end else if (disLevel == DIS_LOW) begin
        {s_next.chanOut[i], s_next.chanOe[i]} = padDrive(1'b0, pushPull);
      end else if (disLevel == DIS_HIGH) begin
        // Open-drain cannot drive high, so this floats
        {s_next.chanOut[i], s_next.chanOe[i]} = padDrive(1'b1, pushPull);
      end else begin
        {s_next.chanOut[i], s_next.chanOe[i]} = 2'b00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= DEV_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state; device never transmits, so data is only pulled low
  assign cfgState = s_reg.cfg;
  assign chanOut = s_reg.chanOut;
  assign chanOe = s_reg.chanOe;
  assign softResetPulse = s_reg.softRst;
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe = s_reg.sdaOe;
  assign link.devSclOut = 1'b0;
  assign link.devSclOe = 1'b0; // No clock stretching

endmodule
`default_nettype wire

//--- hdl/ogbr_host.sv
// Host end: AXI4-Lite controlled serial master that issues reset calls
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ogbr_host
  import ogbr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ogbr_link_if.host link
);

  typedef struct packed {
    logic [2:0] sclSync;
    logic sclF;
    logic [2:0] sdaSync;
    logic sdaF;
    ogbr_host_state_t st;
    logic [5:0] qCnt;
    logic [1:0] q;
    logic [3:0] bitIdx;
    logic [1:0] byteIdx;
    logic nack;
    logic sclOe;
    logic sdaOe;
    logic [31:0] cmd;
    logic goPend;
    logic busy;
    logic done;
    logic abort;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } ogbr_host_s_t;

  localparam ogbr_host_s_t HOST_RST = '{
    sclSync: {3{LINE_IDLE}}, sclF: LINE_IDLE, sdaSync: {3{LINE_IDLE}}, sdaF: LINE_IDLE,
    st: H_IDLE, qCnt: 6'h00, q: 2'h0, bitIdx: 4'h0, byteIdx: 2'h0, nack: 1'b0,
    sclOe: 1'b0, sdaOe: 1'b0, cmd: CMD_RST, goPend: 1'b0, busy: 1'b0, done: 1'b0,
    abort: 1'b0, awHeld: 1'b0, awAddr: 8'h00, wHeld: 1'b0, wData: 32'h0000_0000,
    wStrb: 4'h0, awReady: 1'b1, wReady: 1'b1, bValid: 1'b0, bResp: RESP_OKAY,
    arReady: 1'b1, rValid: 1'b0, rData: 32'h0000_0000, rResp: RESP_OKAY
  };

  ogbr_host_s_t s_reg;
  ogbr_host_s_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte sequence: address first, then up to two copies of the data byte

  function automatic logic [7:0] callByte(input logic [31:0] cmd, input logic [1:0] idx);
    callByte = (idx == 2'h0) ? cmd[CMD_ADDR_LSB +: 8] : cmd[CMD_DATA_LSB +: 8];
  endfunction

  always_comb begin
    logic tick;
    logic [1:0] lastByte;
    logic [7:0] curByte;
    tick = 1'b0;
    lastByte = 2'h0;
    curByte = 8'h00;
    s_next = s_reg;

    // Line synchronisers, same filter as the device
    s_next.sclSync = {s_reg.sclSync[1:0], link.scl};
    s_next.sdaSync = {s_reg.sdaSync[1:0], link.sda};
    if (s_reg.sclSync[1] == s_reg.sclSync[2]) begin
      s_next.sclF = s_reg.sclSync[2];
    end
    if (s_reg.sdaSync[1] == s_reg.sdaSync[2]) begin
      s_next.sdaF = s_reg.sdaSync[2];
    end

    // AXI write: address and data taken in either order
    if (s_reg.awReady && s_axi_awvalid) begin
      s_next.awHeld = 1'b1;
      s_next.awAddr = s_axi_awaddr;
    end
    if (s_reg.wReady && s_axi_wvalid) begin
      s_next.wHeld = 1'b1;
      s_next.wData = s_axi_wdata;
      s_next.wStrb = s_axi_wstrb;
    end
    if (s_reg.bValid && s_axi_bready) begin
      s_next.bValid = 1'b0;
    end
    if (s_next.awHeld && s_next.wHeld && !s_reg.bValid) begin
      s_next.awHeld = 1'b0;
      s_next.wHeld = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = RESP_OKAY;
      unique case (s_next.awAddr)
        REG_CMD: begin
          for (int b = 0; b < 4; b++) begin
            if (s_next.wStrb[b]) begin
              s_next.cmd[8*b +: 8] = s_next.wData[8*b +: 8];
            end
          end
        end
        REG_GO: begin
          // A start request while busy is dropped
          if (s_next.wStrb[0] && s_next.wData[GO_BIT] && !s_reg.busy) begin
            s_next.goPend = 1'b1;
            s_next.busy = 1'b1;
            s_next.done = 1'b0;
            s_next.abort = 1'b0;
          end
        end
        REG_STATUS: begin
          s_next.bResp = RESP_OKAY;
        end
        default: begin
          s_next.bResp = RESP_SLVERR;
        end
      endcase
    end
    s_next.awReady = !s_next.awHeld;
    s_next.wReady = !s_next.wHeld;

    // AXI read
    if (s_reg.rValid && s_axi_rready) begin
      s_next.rValid = 1'b0;
    end
    if (s_reg.arReady && s_axi_arvalid) begin
      s_next.rValid = 1'b1;
      s_next.rResp = RESP_OKAY;
      s_next.rData = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_CMD: s_next.rData = s_reg.cmd;
        REG_GO: s_next.rData = 32'h0000_0000;
        REG_STATUS: begin
          s_next.rData[STAT_BUSY_BIT] = s_reg.busy;
          s_next.rData[STAT_DONE_BIT] = s_reg.done;
          s_next.rData[STAT_ABORT_BIT] = s_reg.abort;
        end
        default: s_next.rResp = RESP_SLVERR;
      endcase
    end
    s_next.arReady = !s_next.rValid;

    // Quarter-period divider runs only while a call is on the bus
    lastByte = 2'h0 + {1'b0, s_reg.cmd[CMD_SEND_BIT]}
      + {1'b0, s_reg.cmd[CMD_SEND_BIT] & s_reg.cmd[CMD_EXTRA_BIT]};
    curByte = callByte(s_reg.cmd, s_reg.byteIdx);
    if (s_reg.st != H_IDLE) begin
      tick = (s_reg.qCnt == QTR_LAST);
      s_next.qCnt = tick ? 6'h00 : s_reg.qCnt + 6'h01;
      if (tick) begin
        s_next.q = s_reg.q + 2'h1;
      end
    end

    // Bit engine; open-drain, so driving means pulling low
    unique case (s_reg.st)
      H_IDLE: begin
        if (s_reg.goPend && s_reg.sclF && s_reg.sdaF) begin
          s_next.st = H_START;
          s_next.goPend = 1'b0;
          s_next.qCnt = 6'h00;
          s_next.q = 2'h0;
        end
      end
      H_START: begin
        if (tick && s_reg.q == 2'h0) s_next.sdaOe = 1'b1;
        if (tick && s_reg.q == 2'h1) s_next.sclOe = 1'b1;
        if (tick && s_reg.q == 2'h3) begin
          s_next.st = H_BITS;
          s_next.bitIdx = 4'h0;
          s_next.byteIdx = 2'h0;
        end
      end
      H_BITS: begin
        if (tick && s_reg.q == 2'h0) begin
          // Data changes only while the clock is low
          s_next.sdaOe = (s_reg.bitIdx == BITS_PER_BYTE) ? 1'b0
            : !curByte[3'h7 - s_reg.bitIdx[2:0]];
        end
        if (tick && s_reg.q == 2'h1) s_next.sclOe = 1'b0;
        if (tick && s_reg.q == 2'h2) s_next.nack = s_reg.sdaF;
        if (tick && s_reg.q == 2'h3) begin
          s_next.sclOe = 1'b1;
          if (s_reg.bitIdx != BITS_PER_BYTE) begin
            s_next.bitIdx = s_reg.bitIdx + 4'h1;
          end else if (s_reg.nack) begin
            s_next.abort = 1'b1;
            s_next.st = H_STOP;
          end else if (s_reg.byteIdx == lastByte) begin
            s_next.st = H_STOP;
          end else begin
            s_next.byteIdx = s_reg.byteIdx + 2'h1;
            s_next.bitIdx = 4'h0;
          end
        end
      end
      H_STOP: begin
        if (tick && s_reg.q == 2'h0) s_next.sdaOe = 1'b1;
        if (tick && s_reg.q == 2'h1) s_next.sclOe = 1'b0;
        if (tick && s_reg.q == 2'h2) s_next.sdaOe = 1'b0;
        if (tick && s_reg.q == 2'h3) begin
          s_next.st = H_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= HOST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs from state; both the write and the read channel are answered from registers
  assign s_axi_awready = s_reg.awReady;
  assign s_axi_wready = s_reg.wReady;
  assign s_axi_bvalid = s_reg.bValid;
  assign s_axi_bresp = s_reg.bResp;
  assign s_axi_arready = s_reg.arReady;
  assign s_axi_rvalid = s_reg.rValid;
  assign s_axi_rdata = s_reg.rData;
  assign s_axi_rresp = s_reg.rResp;
  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe = s_reg.sclOe;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe = s_reg.sdaOe;

endmodule
`default_nettype wire

//--- sim/ogbr_link_chk.sv
// Checker: wire rules of the serial link between host and device
`timescale 1ns/1ps
`default_nettype none
module ogbr_link_chk
  import ogbr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOe
);
  logic [7:0] riseCnt_reg;
  logic [7:0] bits_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // Clock rises since START and the bits they carried; START restarts framing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      riseCnt_reg <= 8'h00;
      bits_reg <= 8'h00;
    end else if ($fell(sda) && scl) begin
      riseCnt_reg <= 8'h00;
    end else if ($rose(scl)) begin
      riseCnt_reg <= riseCnt_reg + 8'h01;
      bits_reg <= {bits_reg[6:0], sda};
    end
  end
  ////////////////////////////////////////////////////////////////
  // Acknowledge timing against the clock
  a_ack_steady_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("ack moved in clock high");
  a_ack_set_low: assert property ($rose(devSdaOe) |-> !scl ##1 devSdaOe [*8])
    else $error("ack set badly");
  a_ack_free_low: assert property ($fell(devSdaOe) |-> !scl && !$past(scl))
    else $error("ack freed in clock high");
  // Framing; the count check is what catches a miscounted bit
  a_start_hold: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("clock fell after start");
  a_stop_bytes: assert property ($rose(sda) && scl && $past(scl)
    |-> riseCnt_reg % 8'd9 == 8'd1) else $error("stop inside a byte");
  a_addr_ack: assert property ($rose(scl) && riseCnt_reg == 8'd8
    |-> (sda == 1'b0) == (bits_reg == 8'h00)) else $error("address ack wrong");
  a_cmd_ack: assert property ($rose(scl) && riseCnt_reg == 8'd17
    |-> (sda == 1'b0) == (bits_reg == 8'h06)) else $error("command ack wrong");
  a_extra_nack: assert property ($rose(scl) && riseCnt_reg == 8'd26 |-> sda)
    else $error("extra byte acked");
  a_nack_stop: assert property ($rose(scl) && riseCnt_reg % 8'd9 == 8'd8 && sda
    |-> ##[1:300] ($rose(sda) && scl)) else $error("no stop after refusal");
  c_full_call: cover property ($rose(scl) && riseCnt_reg == 8'd17 && !sda);
  c_addr_nack: cover property ($rose(scl) && riseCnt_reg == 8'd8 && sda);
  c_extra_byte: cover property ($rose(scl) && riseCnt_reg == 8'd26);
endmodule
`default_nettype wire

//--- sim/tb_output_gate_and_bus_reset.sv
// Testbench: host and device joined by the link; gating table and reset calls
`timescale 1ns/1ps
`default_nettype none
module tb_output_gate_and_bus_reset
  import ogbr_pkg::*;
;
  typedef struct {logic oeN; logic [3:0] cfg; logic [15:0] out; logic [15:0] oe;} ogbr_row_t;
  typedef struct {logic [31:0] cmd; logic [31:0] stat; logic [3:0] cfg; int rst;} ogbr_call_t;
  logic clk = 1'b0, sysRst = 1'b1, outEnableN = 1'b1, cfgWrite = 1'b0;
  logic [15:0] pwmState = 16'ha5c3;
  logic [3:0] cfgData = 4'h0;
  logic [3:0] cfgState;
  logic [15:0] chanOut, chanOe;
  logic softResetPulse, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  int fails = 0, checks = 0, pulses = 0;
  // Enable, config, expected value and expected drive per row
  ogbr_row_t rows [11] = '{
    '{1'b0, 4'h4, 16'ha5c3, 16'hffff}, '{1'b0, 4'hc, 16'h5a3c, 16'hffff},
    '{1'b0, 4'h0, 16'h0000, 16'h5a3c}, '{1'b0, 4'h8, 16'h0000, 16'ha5c3},
    '{1'b1, 4'h4, 16'h0000, 16'hffff}, '{1'b1, 4'hc, 16'h0000, 16'hffff},
    '{1'b1, 4'h5, 16'hffff, 16'hffff}, '{1'b1, 4'h1, 16'h0000, 16'h0000},
    '{1'b1, 4'h6, 16'h0000, 16'h0000}, '{1'b1, 4'h3, 16'h0000, 16'h0000},
    '{1'b1, 4'h0, 16'h0000, 16'hffff}};
  // Good call, read address, wrong byte, extra byte
  ogbr_call_t calls [4] = '{
    '{32'h0001_0600, 32'h2, 4'h4, 1}, '{32'h0000_0001, 32'h6, 4'hc, 0},
    '{32'h0001_0700, 32'h6, 4'hc, 0}, '{32'h0003_0600, 32'h6, 4'hc, 0}};
  ogbr_link_if linkBus();
  ogbr_device ogbr_device_inst (.clk(clk), .sys_rst(sysRst), .outEnableN(outEnableN),
    .pwmState(pwmState), .cfgWrite(cfgWrite), .cfgData(cfgData), .cfgState(cfgState),
    .chanOut(chanOut), .chanOe(chanOe), .softResetPulse(softResetPulse), .link(linkBus));
  ogbr_host ogbr_host_inst (.clk(clk), .sys_rst(sysRst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(linkBus));
  ogbr_link_chk ogbr_link_chk_inst (.clk(clk), .sys_rst(sysRst), .scl(linkBus.scl),
    .sda(linkBus.sda), .devSdaOe(linkBus.devSdaOe));
  ////////////////////////////////////////////////////////////////
  // Clock, and a count of soft reset pulses since a pulse lasts one cycle
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) begin
    if (softResetPulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic conclude();
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      conclude();
    end
  endtask
  // Config strobe lasts exactly one cycle
  task automatic setCfg(input logic [3:0] v);
    cfgWrite <= 1'b1;
    cfgData <= v;
    @(posedge clk);
    cfgWrite <= 1'b0;
  endtask
  // Bus cycles; an edge passes first so no strobe is set twice in a step
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic got;
    @(posedge clk);
    n = 0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && n < 200) begin
      @(posedge clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        got = 1'b1;
        bready <= 1'b0;
      end
    end
    bound(got ? 0 : n, 200);
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic got;
    @(posedge clk);
    n = 0;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 200) begin
      @(posedge clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        got = 1'b1;
        rready <= 1'b0;
      end
    end
    bound(got ? 0 : n, 200);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int base;
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    cmp({chanOe, chanOut}, 32'hffff_0000);
    cmp(32'(cfgState), 32'(CFG_RST));
    axiRead(REG_CMD, d, r);
    cmp(d, CMD_RST);
    // Gating table; all sixteen channels compared at one moment
    foreach (rows[i]) begin
      setCfg(rows[i].cfg);
      outEnableN <= rows[i].oeN;
      repeat (8) @(posedge clk);
      cmp(32'(chanOe), 32'(rows[i].oe));
      cmp(32'(chanOut & rows[i].oe), 32'(rows[i].out));
    end
    // Enabled outputs track a new PWM pattern, not a fixed one
    setCfg(CFG_RST);
    outEnableN <= 1'b0;
    pwmState <= 16'h3c5a;
    repeat (8) @(posedge clk);
    cmp({chanOe, chanOut}, 32'hffff_3c5a);
    // Reset calls, good and malformed; status polled with a bound
    foreach (calls[i]) begin
      setCfg(4'hc);
      base = pulses;
      axiWrite(REG_CMD, calls[i].cmd, r);
      axiWrite(REG_GO, 32'h1, r);
      n = 0;
      d = 32'h0;
      // Abort shows before the STOP ends, so wait for done with busy clear
      while ((d & 32'h3) != 32'h2 && n < 3000) begin
        axiRead(REG_STATUS, d, r);
        n++;
      end
      bound(((d & 32'h3) == 32'h2) ? 0 : n, 3000);
      repeat (8) @(posedge clk);
      cmp(d & 32'h7, calls[i].stat);
      cmp(32'(pulses - base), 32'(calls[i].rst));
      cmp(32'(cfgState), 32'(calls[i].cfg));
    end
    // Mid-run reset brings both ends back to power-up values
    setCfg(4'hb);
    axiWrite(REG_CMD, 32'h0000_0001, r);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    cmp(32'(cfgState), 32'(CFG_RST));
    axiRead(REG_CMD, d, r);
    cmp(d, CMD_RST);
    // Unmapped places answer with an error
    axiWrite(8'h10, 32'h0, r);
    cmp(32'(r), 32'(RESP_SLVERR));
    axiRead(8'h0c, d, r);
    cmp({d[29:0], r}, {30'h0, RESP_SLVERR});
    conclude();
  end
endmodule
`default_nettype wire
